// >>> adc_ctl_pkg.sv
// Function
// - Any write to control register 0 aborts the running sequence.
// - Control register 1 reads only in special mode; writes do nothing.
// - Any write to control register 2 aborts the running sequence.
// - Power-up bit 0 gates the converter clock and powers analog down.
// - Clearing the power-up bit aborts the running sequence.
// - Fast-clear 0: status read then result read clears the complete flag.
// - Fast-clear 1: any result access clears its set complete flag.
// - Stop-in-wait 1 halts the converter in wait mode; 0 keeps running.
// - Interrupt enable 1 requests an interrupt on sequence completion.
// - Sequence interrupt flag reads 1 after completion; writes ignored.
// - Write to control register 3 aborts the sequence and suspends at breakpoint.
// - Freeze field: 00 run, 10 finish then freeze, 11 freeze now, 01 reserved.
// - Resolution bit: 0 gives 8-bit, 1 gives 10-bit conversions.
// - Sample field gives 2, 4, 8 or 16 converter clocks of final sample.
// - Conversion lasts sample time plus 16 (8-bit) or 18 (10-bit) clocks.
// - Converter clock is P clock over prescale plus one, then halved.
// - Prescale 00000 divides by 2 in total; reset value 00001 by 4.
// - Write to control register 4 aborts; halted until register 5 written.
// - Write to register 5 starts a new sequence and clears both flag kinds.
// - After four or eight conversions set sequence flag; halt or rescan.
package adc_ctl_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL_0   = 8'h60;
	localparam logic [7:0] IDX_RESERVED_1  = 8'h61;
	localparam logic [7:0] IDX_POWER_IRQ   = 8'h62;
	localparam logic [7:0] IDX_FREEZE      = 8'h63;
	localparam logic [7:0] IDX_TIMING      = 8'h64;
	localparam logic [7:0] IDX_SEQ_START   = 8'h65;
	localparam logic [7:0] IDX_STATUS_SEQ  = 8'h66;
	localparam logic [7:0] IDX_STATUS_CONV = 8'h67;
	localparam logic [7:0] IDX_RESULT_BASE = 8'h70;

	// Power/irq register fields
	localparam int POS_POWER_UP   = 7;
	localparam int POS_FAST_CLEAR = 6;
	localparam int POS_STOP_WAIT  = 5;
	localparam int POS_IRQ_EN     = 1;
	localparam int POS_IRQ_FLAG   = 0;

	// Timing register fields
	localparam int POS_RESOLUTION = 7;
	localparam int POS_SMP_LO     = 5;
	localparam int POS_PRS_LO     = 0;

	// Sequence start register fields
	localparam int POS_EIGHT_CH = 6;
	localparam int POS_SCAN     = 5;
	localparam int POS_MULTI    = 4;

	localparam logic [7:0] RST_POWER_IRQ = 8'h00;
	localparam logic [1:0] RST_FREEZE    = 2'h0;
	localparam logic [7:0] RST_TIMING    = 8'h01;
	localparam logic [7:0] RST_SEQ_START = 8'h00;
	localparam logic [7:0] RESERVED_1_READ = 8'h00;

	localparam logic [5:0] CONV_CLKS_8BIT  = 6'h10;
	localparam logic [5:0] CONV_CLKS_10BIT = 6'h12;
	localparam logic [5:0] SAMPLE_CLKS_MIN = 6'h02;

	localparam logic [1:0] FRZ_RUN    = 2'h0;
	localparam logic [1:0] FRZ_FINISH = 2'h2;
	localparam logic [1:0] FRZ_NOW    = 2'h3;

	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_t;

endpackage

// >>> adc_control_prescaler.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module adc_control_prescaler
	import adc_ctl_pkg::*;
#(
	parameter int RESULT_W = 10
) (
	input  wire logic                core_clk_i,
	input  wire logic                nrst_i,
	input  wire logic [9:0]          address_i,
	input  wire logic                read_i,
	input  wire logic                write_i,
	input  wire logic [31:0]         writedata_i,
	output logic      [31:0]         readdata_o,
	output logic                     waitrequest_o,
	input  wire logic                special_mode_i,
	input  wire logic                wait_mode_i,
	input  wire logic                background_debug_state_i,
	input  wire logic [RESULT_W-1:0] conv_data_i,
	output logic                     power_up_o,
	output logic                     adc_clk_o,
	output logic                     sample_o,
	output logic [2:0]               channel_o,
	output logic                     irq_o
);

	// The result path and the 8-bit packing assume ten converter bits
	if (RESULT_W != 10) begin : g_bad_width
		$error("RESULT_W must be 10");
	end

	logic [7:0]          power_ctl;
	logic [1:0]          freeze_sel;
	logic [7:0]          timing_ctl;
	logic [7:0]          seq_ctl;
	logic                sequence_complete_flag;
	logic                seq_done_irq_flag;
	logic [7:0]          conversion_complete_flag;
	logic [7:0]          clear_armed;
	logic [2:0]          conv_idx;
	logic [RESULT_W-1:0] result [8];
	seq_state_t          state;
	logic [5:0]          phase_cnt;
	logic                at_start;
	logic [4:0]          prs_cnt;
	logic                tick;

	wire logic [7:0] idx      = address_i[9:2];
	wire logic       acc      = (read_i || write_i) && !waitrequest_o;
	wire logic       wr       = write_i && !waitrequest_o;
	wire logic       rd       = read_i && !waitrequest_o;
	wire logic [7:0] wbyte    = writedata_i[7:0];
	wire logic       res_hit  = (idx[7:3] == IDX_RESULT_BASE[7:3]);
	wire logic [2:0] res_sel  = idx[2:0];

	wire logic power_up_bit    = power_ctl[POS_POWER_UP];
	wire logic fast_flag_clear = power_ctl[POS_FAST_CLEAR];
	wire logic stop_in_wait    = power_ctl[POS_STOP_WAIT];
	wire logic seq_done_irq_enable = power_ctl[POS_IRQ_EN];
	wire logic resolution_select   = timing_ctl[POS_RESOLUTION];
	wire logic [1:0] sample_time   = timing_ctl[POS_SMP_LO +: 2];
	wire logic [4:0] clock_prescale_value = timing_ctl[POS_PRS_LO +: 5];

	// Aborting writes: registers 0, 2, 3, 4, and power-down
	wire logic wr_ctl5  = wr && (idx == IDX_SEQ_START);
	wire logic abort = wr && (idx == IDX_CONTROL_0
		|| idx == IDX_POWER_IRQ
		|| idx == IDX_FREEZE
		|| idx == IDX_TIMING);
	wire logic power_drop = wr && idx == IDX_POWER_IRQ && !wbyte[POS_POWER_UP];

	// Hold conditions for wait mode and background debug
	wire logic hold_wait = wait_mode_i && stop_in_wait;
	wire logic hold_now  = background_debug_state_i && freeze_sel == FRZ_NOW;
	wire logic hold_soft = background_debug_state_i && freeze_sel == FRZ_FINISH
		&& state == ST_SAMPLE && at_start;
	wire logic run = power_up_bit && !hold_wait && !hold_now && !hold_soft;

	wire logic [5:0] sample_len = SAMPLE_CLKS_MIN << sample_time;
	wire logic [5:0] conv_len   = resolution_select ? CONV_CLKS_10BIT : CONV_CLKS_8BIT;
	wire logic       last_conv  = conv_idx == (seq_ctl[POS_EIGHT_CH] ? 3'h7 : 3'h3);
	wire logic       conv_end   = tick && run && state == ST_CONVERT && phase_cnt == 6'h00;

	// Avalon slave: one wait state, read data registered with the wait drop
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			waitrequest_o <= 1'b1;
		end else begin
			waitrequest_o <= !((read_i || write_i) && waitrequest_o);
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			readdata_o <= 32'h0000_0000;
		end else if (read_i && waitrequest_o) begin
			readdata_o <= 32'h0000_0000;
			if (idx == IDX_RESERVED_1) begin
				readdata_o[7:0] <= special_mode_i ? RESERVED_1_READ : 8'h00;
			end else if (idx == IDX_POWER_IRQ) begin
				readdata_o[7:0] <= {power_ctl[7:1], seq_done_irq_flag};
			end else if (idx == IDX_FREEZE) begin
				readdata_o[1:0] <= freeze_sel;
			end else if (idx == IDX_TIMING) begin
				readdata_o[7:0] <= timing_ctl;
			end else if (idx == IDX_SEQ_START) begin
				readdata_o[7:0] <= seq_ctl;
			end else if (idx == IDX_STATUS_SEQ) begin
				readdata_o[7:0] <= {sequence_complete_flag, 4'h0, conv_idx};
			end else if (idx == IDX_STATUS_CONV) begin
				readdata_o[7:0] <= conversion_complete_flag;
			end else if (res_hit) begin
				readdata_o[RESULT_W-1:0] <= result[res_sel];
			end
		end
	end

	// Control registers; register 1 and the irq flag bit take no write
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			power_ctl  <= RST_POWER_IRQ;
			freeze_sel <= RST_FREEZE;
			timing_ctl <= RST_TIMING;
			seq_ctl    <= RST_SEQ_START;
		end else if (wr) begin
			if (idx == IDX_POWER_IRQ) begin
				power_ctl <= {wbyte[7:5], 3'h0, wbyte[POS_IRQ_EN], 1'b0};
			end else if (idx == IDX_FREEZE) begin
				freeze_sel <= wbyte[1:0];
			end else if (idx == IDX_TIMING) begin
				timing_ctl <= wbyte;
			end else if (idx == IDX_SEQ_START) begin
				seq_ctl <= {1'b0, wbyte[6:0]};
			end
		end
	end

	// Prescaler: count 0..prescale, toggle, giving 2*(prescale+1) P clocks
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prs_cnt   <= 5'h00;
			adc_clk_o <= 1'b0;
			tick      <= 1'b0;
		end else if (!power_up_bit) begin
			prs_cnt   <= 5'h00;
			adc_clk_o <= 1'b0;
			tick      <= 1'b0;
		end else if (prs_cnt >= clock_prescale_value) begin
			prs_cnt   <= 5'h00;
			adc_clk_o <= !adc_clk_o;
			tick      <= !adc_clk_o;
		end else begin
			prs_cnt <= prs_cnt + 5'h01;
			tick    <= 1'b0;
		end
	end

	// Sequencer
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state     <= ST_IDLE;
			phase_cnt <= 6'h00;
			conv_idx  <= 3'h0;
			at_start  <= 1'b0;
		end else if (abort || power_drop || !power_up_bit) begin
			state    <= ST_IDLE;
			conv_idx <= 3'h0;
			at_start <= 1'b0;
		end else if (wr_ctl5) begin
			state     <= ST_SAMPLE;
			phase_cnt <= sample_len - 6'h01;
			conv_idx  <= 3'h0;
			at_start  <= 1'b1;
		end else if (tick && run && state != ST_IDLE) begin
			at_start <= 1'b0;
			if (phase_cnt != 6'h00) begin
				phase_cnt <= phase_cnt - 6'h01;
			end else if (state == ST_SAMPLE) begin
				state     <= ST_CONVERT;
				phase_cnt <= conv_len - 6'h01;
			end else begin
				conv_idx  <= conv_idx + 3'h1;
				at_start  <= 1'b1;
				phase_cnt <= sample_len - 6'h01;
				if (last_conv) begin
					conv_idx <= 3'h0;
					state    <= seq_ctl[POS_SCAN] ? ST_SAMPLE : ST_IDLE;
				end else begin
					state <= ST_SAMPLE;
				end
			end
		end
	end

	// Results; 8-bit mode keeps the upper bits in the low byte
	always_ff @(posedge core_clk_i) begin
		if (conv_end) begin
			result[conv_idx] <= resolution_select ? conv_data_i
				: {2'h0, conv_data_i[RESULT_W-1:2]};
		end
	end

	// Sequence flags; completion wins over any clear in the same cycle
	wire logic seq_done  = conv_end && last_conv;
	wire logic scf_clear = (wr_ctl5 && !fast_flag_clear)
		|| (fast_flag_clear && rd && res_hit) || (wr_ctl5 && fast_flag_clear);
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sequence_complete_flag <= 1'b0;
			seq_done_irq_flag      <= 1'b0;
		end else if (seq_done) begin
			sequence_complete_flag <= 1'b1;
			seq_done_irq_flag      <= 1'b1;
		end else if (scf_clear) begin
			sequence_complete_flag <= 1'b0;
			seq_done_irq_flag      <= 1'b0;
		end
	end

	// Complete flags: per-bit clear arming and clearing
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_ccf
			wire logic set_g = conv_end && conv_idx == g;
			wire logic hit_g = acc && res_hit && res_sel == g;
			always_ff @(posedge core_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					conversion_complete_flag[g] <= 1'b0;
					clear_armed[g]              <= 1'b0;
				end else begin
					if (set_g) begin
						conversion_complete_flag[g] <= 1'b1;
					end else if (wr_ctl5) begin
						conversion_complete_flag[g] <= 1'b0;
					end else if (hit_g && (fast_flag_clear || (rd && clear_armed[g]))) begin
						conversion_complete_flag[g] <= 1'b0;
					end
					if (rd && idx == IDX_STATUS_CONV) begin
						clear_armed[g] <= conversion_complete_flag[g];
					end else if (hit_g || set_g) begin
						clear_armed[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Analog-side outputs and interrupt
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			power_up_o <= 1'b0;
			sample_o   <= 1'b0;
			channel_o  <= 3'h0;
			irq_o      <= 1'b0;
		end else begin
			power_up_o <= power_up_bit;
			sample_o   <= state == ST_SAMPLE;
			irq_o      <= seq_done_irq_flag && seq_done_irq_enable;
			if (!seq_ctl[POS_MULTI]) begin
				channel_o <= seq_ctl[2:0];
			end else if (seq_ctl[POS_EIGHT_CH]) begin
				channel_o <= conv_idx;
			end else begin
				channel_o <= {seq_ctl[2], conv_idx[1:0]};
			end
		end
	end

	// Helper: P clocks since the last converter clock tick
	logic [6:0] tick_gap;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_gap <= 7'h00;
		end else if (tick || !power_up_bit) begin
			tick_gap <= 7'h00;
		end else if (tick_gap != 7'h7f) begin
			tick_gap <= tick_gap + 7'h01;
		end
	end

	// Ticks since the last prescale write; the first period after a change is irregular
	logic [1:0] ticks_since_cfg;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ticks_since_cfg <= 2'h0;
		end else if (!power_up_bit || (wr && idx == IDX_TIMING)) begin
			ticks_since_cfg <= 2'h0;
		end else if (tick && ticks_since_cfg != 2'h2) begin
			ticks_since_cfg <= ticks_since_cfg + 2'h1;
		end
	end

	sequence s_ctl0_write;
		wr && idx == IDX_CONTROL_0;
	endsequence
	sequence s_idle_next;
		##1 state == ST_IDLE;
	endsequence

	property p_ctl0_abort;
		@(posedge core_clk_i) disable iff (!nrst_i) s_ctl0_write |-> s_idle_next;
	endproperty
	a_ctl0_abort: assert property (p_ctl0_abort) else $error("control 0 write did not abort");

	property p_ctl1_no_effect;
		@(posedge core_clk_i) disable iff (!nrst_i)
		wr && idx == IDX_RESERVED_1 && state != ST_IDLE && !tick |=> state == $past(state);
	endproperty
	a_ctl1_no_effect: assert property (p_ctl1_no_effect) else $error("control 1 write acted");

	property p_ctl2_abort;
		@(posedge core_clk_i) disable iff (!nrst_i) wr && idx == IDX_POWER_IRQ |=> state == ST_IDLE;
	endproperty
	a_ctl2_abort: assert property (p_ctl2_abort) else $error("control 2 write did not abort");

	property p_power_gate;
		@(posedge core_clk_i) disable iff (!nrst_i) !power_up_bit ##1 !power_up_bit |-> !adc_clk_o && !tick;
	endproperty
	a_power_gate: assert property (p_power_gate) else $error("clock runs while powered down");

	property p_irq_flag_ro;
		@(posedge core_clk_i) disable iff (!nrst_i)
		wr && idx == IDX_POWER_IRQ && !seq_done |=> $stable(seq_done_irq_flag);
	endproperty
	a_irq_flag_ro: assert property (p_irq_flag_ro) else $error("irq flag took a write");

	property p_irq_out;
		@(posedge core_clk_i) disable iff (!nrst_i)
		seq_done_irq_flag && seq_done_irq_enable |=> irq_o ##0 $past(seq_done_irq_flag);
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");

	property p_tick_period;
		@(posedge core_clk_i) disable iff (!nrst_i)
		tick && ticks_since_cfg == 2'h2 |-> tick_gap == {1'b0, clock_prescale_value, 1'b1};
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("prescale period wrong");

	property p_ctl5_clears;
		@(posedge core_clk_i) disable iff (!nrst_i)
		wr_ctl5 && !conv_end |=> !sequence_complete_flag && conversion_complete_flag == 8'h00;
	endproperty
	a_ctl5_clears: assert property (p_ctl5_clears) else $error("start did not clear flags");

	property p_freeze_now;
		@(posedge core_clk_i) disable iff (!nrst_i)
		hold_now && !abort && !wr_ctl5 ##1 hold_now |-> $stable(phase_cnt) && $stable(state);
	endproperty
	a_freeze_now: assert property (p_freeze_now) else $error("ran while frozen");

	property p_wait_stop;
		@(posedge core_clk_i) disable iff (!nrst_i)
		hold_wait && !abort && !wr_ctl5 && !power_drop |=> $stable(phase_cnt);
	endproperty
	a_wait_stop: assert property (p_wait_stop) else $error("ran in wait mode");

	property p_fast_clear;
		@(posedge core_clk_i) disable iff (!nrst_i)
		fast_flag_clear && acc && res_hit && !conv_end && !wr_ctl5 |=> !conversion_complete_flag[$past(res_sel)];
	endproperty
	a_fast_clear: assert property (p_fast_clear) else $error("fast clear failed");

	property p_seq_flag;
		@(posedge core_clk_i) disable iff (!nrst_i) seq_done |=> sequence_complete_flag && seq_done_irq_flag;
	endproperty
	a_seq_flag: assert property (p_seq_flag) else $error("sequence flag not set");

	sequence s_conv_done;
		conv_end && !abort && !wr_ctl5;
	endsequence
	sequence s_sample_done;
		tick && run && state == ST_SAMPLE && phase_cnt == 6'h00 && !abort && !wr_ctl5;
	endsequence

	property p_sample_reload;
		@(posedge core_clk_i) disable iff (!nrst_i)
		s_conv_done ##0 (!last_conv || seq_ctl[POS_SCAN])
		|=> state == ST_SAMPLE && phase_cnt == sample_len - 6'h01;
	endproperty
	a_sample_reload: assert property (p_sample_reload) else $error("sample phase length wrong");

	property p_convert_entry;
		@(posedge core_clk_i) disable iff (!nrst_i)
		s_sample_done |=> state == ST_CONVERT && phase_cnt == conv_len - 6'h01;
	endproperty
	a_convert_entry: assert property (p_convert_entry) else $error("conversion length wrong");

	property p_start_sample;
		@(posedge core_clk_i) disable iff (!nrst_i) wr_ctl5 && power_up_bit |=> state == ST_SAMPLE;
	endproperty
	a_start_sample: assert property (p_start_sample) else $error("start write did not start");

	property p_idle_holds;
		@(posedge core_clk_i) disable iff (!nrst_i) state == ST_IDLE && !wr_ctl5 |=> state == ST_IDLE;
	endproperty
	a_idle_holds: assert property (p_idle_holds) else $error("left idle without a start");

endmodule // adc_control_prescaler

// >>> adc_control_prescaler_test.sv
`timescale 1ns/1ps
module adc_control_prescaler_test;
	import adc_ctl_pkg::*;

	logic        core_clk_i;
	logic        nrst_i;
	logic [9:0]  address_i;
	logic        read_i;
	logic        write_i;
	logic [31:0] writedata_i;
	logic [31:0] readdata_o;
	logic        waitrequest_o;
	logic        special_mode_i;
	logic        wait_mode_i;
	logic        background_debug_state_i;
	logic [9:0]  conv_data_i;
	logic        power_up_o;
	logic        adc_clk_o;
	logic        sample_o;
	logic [2:0]  channel_o;
	logic        irq_o;
	int          n_errors;
	int          num_checks;
	int          samp_cyc;
	int          hi;
	int          tot;
	logic        hit;
	logic [31:0] v;

	adc_control_prescaler #(.RESULT_W(10)) u_adc_control_prescaler (
		.core_clk_i              (core_clk_i),
		.nrst_i                  (nrst_i),
		.address_i               (address_i),
		.read_i                  (read_i),
		.write_i                 (write_i),
		.writedata_i             (writedata_i),
		.readdata_o              (readdata_o),
		.waitrequest_o           (waitrequest_o),
		.special_mode_i          (special_mode_i),
		.wait_mode_i             (wait_mode_i),
		.background_debug_state_i(background_debug_state_i),
		.conv_data_i             (conv_data_i),
		.power_up_o              (power_up_o),
		.adc_clk_o               (adc_clk_o),
		.sample_o                (sample_o),
		.channel_o               (channel_o),
		.irq_o                   (irq_o)
	);

	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end

	// Outputs are looked at on the falling edge, well away from register updates
	always @(negedge core_clk_i) begin
		if (sample_o === 1'b1) samp_cyc++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Request held until waitrequest is sampled low at a rising edge; data taken and request dropped there
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rdata);
		@(posedge core_clk_i);
		address_i   <= {idx, 2'b00};
		writedata_i <= {24'h00_0000, wd};
		write_i     <= wr;
		read_i      <= ~wr;
		do begin
			@(posedge core_clk_i);
		end while (waitrequest_o !== 1'b0);
		rdata = readdata_o;
		write_i <= 1'b0;
		read_i  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] d;
		bus(1'b1, idx, wd, d);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] d);
		bus(1'b0, idx, 8'h00, d);
	endtask

	task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		rd(idx, d);
		check({24'h00_0000, d[7:0]}, {24'h00_0000, exp});
	endtask

	// Polls the sequence flag; each poll costs three clocks
	task automatic wait_seq(input int limit, output logic got);
		logic [31:0] d;
		got = 1'b0;
		for (int i = 0; i < limit && !got; i++) begin
			rd(IDX_STATUS_SEQ, d);
			got = d[7];
		end
	endtask

	function automatic logic sel(input bit c);
		return c ? adc_clk_o : sample_o;
	endfunction

	// High time and full period, in P clocks, of the second pulse seen; the first may be cut short
	task automatic edges(input bit c, output int h, output int t);
		int n;
		@(negedge core_clk_i);
		for (n = 0; n < 500 && sel(c) !== 1'b1; n++) @(negedge core_clk_i);
		for (n = 0; n < 500 && sel(c) !== 1'b0; n++) @(negedge core_clk_i);
		for (n = 0; n < 500 && sel(c) !== 1'b1; n++) @(negedge core_clk_i);
		for (h = 0; h < 500 && sel(c) === 1'b1; h++) @(negedge core_clk_i);
		for (t = h; t < 500 && sel(c) === 1'b0; t++) @(negedge core_clk_i);
	endtask

	task automatic start_wait(input logic [7:0] ctl, input int limit, input logic exp);
		logic got;
		wr(IDX_SEQ_START, ctl);
		wait_seq(limit, got);
		check({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask

	initial begin
		// The tests need well under ten thousand clocks
		repeat (20000) @(posedge core_clk_i);
		n_errors++;
		conclude();
	end

	initial begin
		nrst_i = 1'b0; address_i = '0; read_i = 1'b0; write_i = 1'b0; writedata_i = '0;
		special_mode_i = 1'b0; wait_mode_i = 1'b0; background_debug_state_i = 1'b0;
		conv_data_i = 10'h2A5; n_errors = 0; num_checks = 0; samp_cyc = 0;
		repeat (3) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		rc(IDX_POWER_IRQ, 8'h00);
		rc(IDX_FREEZE, 8'h00);
		rc(IDX_TIMING, 8'h01);
		repeat (20) @(negedge core_clk_i);
		check({30'h0000_0000, power_up_o, adc_clk_o}, 32'h0000_0000);
		wr(IDX_RESERVED_1, 8'hFF);
		special_mode_i <= 1'b1;
		rc(IDX_RESERVED_1, 8'h00);
		special_mode_i <= 1'b0;
		rc(IDX_POWER_IRQ, 8'h00);
		rc(8'h50, 8'h00);
		wr(IDX_POWER_IRQ, 8'h83);
		repeat (8) @(posedge core_clk_i);
		rc(IDX_POWER_IRQ, 8'h82);
		check({31'h0000_0000, power_up_o}, 32'h0000_0001);
		wr(IDX_SEQ_START, 8'h00);
		edges(1'b1, hi, tot);
		check(32'(tot), 32'd4);
		// Divider table: total divisor is twice (prescale plus one), half high
		for (int p = 0; p < 8; p += 7) begin
			wr(IDX_TIMING, 8'(p));
			wr(IDX_SEQ_START, 8'h00);
			edges(1'b1, hi, tot);
			check(32'(tot), 32'(2 * (p + 1)));
			check(32'(hi), 32'(p + 1));
		end
		// Sample phase and conversion length, both resolutions, prescale 0
		for (int r = 0; r < 2; r++) begin
			for (int s = 0; s < 4; s++) begin
				wr(IDX_TIMING, 8'((r << 7) | (s << 5)));
				wr(IDX_SEQ_START, 8'h00);
				edges(1'b0, hi, tot);
				check(32'(hi), 32'(2 * (2 << s)));
				check(32'(tot), 32'(2 * ((2 << s) + 16 + 2 * r)));
			end
		end
		wr(IDX_TIMING, 8'h00);
		start_wait(8'h00, 100, 1'b1);
		samp_cyc = 0;
		repeat (100) @(negedge core_clk_i);
		check(32'(samp_cyc), 32'd0);
		check({31'h0000_0000, irq_o}, 32'h0000_0001);
		wr(IDX_POWER_IRQ, 8'h82);
		rc(IDX_POWER_IRQ, 8'h83);
		wr(IDX_POWER_IRQ, 8'h80);
		repeat (3) @(negedge core_clk_i);
		check({31'h0000_0000, irq_o}, 32'h0000_0000);
		wr(IDX_POWER_IRQ, 8'h82);
		wr(IDX_SEQ_START, 8'h00);
		rc(IDX_POWER_IRQ, 8'h82);
		rc(IDX_STATUS_CONV, 8'h00);
		start_wait(8'h40, 150, 1'b1);
		rc(IDX_STATUS_CONV, 8'hFF);
		// Normal clearing needs the status read first; fast clearing does not
		wr(IDX_TIMING, 8'h80);
		start_wait(8'h00, 100, 1'b1);
		rd(IDX_RESULT_BASE + 8'h01, v);
		check({22'h00_0000, v[9:0]}, 32'h0000_02A5);
		rc(IDX_STATUS_CONV, 8'h0F);
		rd(IDX_RESULT_BASE + 8'h01, v);
		rc(IDX_STATUS_CONV, 8'h0D);
		wr(IDX_TIMING, 8'h00);
		wr(IDX_POWER_IRQ, 8'hC2);
		start_wait(8'h00, 100, 1'b1);
		rd(IDX_RESULT_BASE, v);
		check({24'h00_0000, v[7:0]}, 32'h0000_00A9);
		rc(IDX_STATUS_CONV, 8'h0E);
		wr(IDX_POWER_IRQ, 8'h82);
		// Two register 1 writes three clocks apart meet both converter clock phases
		wr(IDX_SEQ_START, 8'h00);
		wr(IDX_RESERVED_1, 8'hFF);
		wr(IDX_RESERVED_1, 8'hFF);
		wait_seq(100, hit);
		check({31'h0000_0000, hit}, 32'h0000_0001);
		// Control writes in mid-sequence abort and leave the converter idle
		for (int k = 0; k < 5; k++) begin
			wr(IDX_SEQ_START, 8'h00);
			for (int n = 0; n < 200 && sample_o !== 1'b1; n++) @(negedge core_clk_i);
			case (k)
				0: wr(IDX_CONTROL_0, 8'h00);
				1: wr(IDX_POWER_IRQ, 8'h82);
				2: wr(IDX_FREEZE, 8'h00);
				3: wr(IDX_TIMING, 8'h00);
				default: wr(IDX_POWER_IRQ, 8'h02);
			endcase
			@(posedge core_clk_i);
			samp_cyc = 0;
			wait_seq(60, hit);
			check({31'h0000_0000, hit}, 32'h0000_0000);
			check(32'(samp_cyc), 32'd0);
		end
		check({30'h0000_0000, power_up_o, adc_clk_o}, 32'h0000_0000);
		// Wait mode halts only with stop-in-wait set
		wr(IDX_POWER_IRQ, 8'hA2);
		wait_mode_i <= 1'b1;
		start_wait(8'h00, 60, 1'b0);
		wait_mode_i <= 1'b0;
		wait_seq(100, hit);
		check({31'h0000_0000, hit}, 32'h0000_0001);
		wr(IDX_POWER_IRQ, 8'h82);
		wait_mode_i <= 1'b1;
		start_wait(8'h00, 100, 1'b1);
		wait_mode_i <= 1'b0;
		// Debug response per freeze code: 00 runs, 10 and 11 hold
		for (int f = 0; f < 4; f++) begin
			if (f != 1) begin
				wr(IDX_FREEZE, 8'(f));
				background_debug_state_i <= 1'b1;
				start_wait(8'h00, 100, f == 0);
				background_debug_state_i <= 1'b0;
				wait_seq(100, hit);
				check({31'h0000_0000, hit}, 32'h0000_0001);
			end
		end
		wr(IDX_FREEZE, 8'h00);
		wr(IDX_SEQ_START, 8'h07);
		repeat (2) @(negedge core_clk_i);
		check({29'h0000_0000, channel_o}, 32'h0000_0007);
		wr(IDX_SEQ_START, 8'h17);
		repeat (2) @(negedge core_clk_i);
		check({29'h0000_0000, channel_o}, 32'h0000_0004);
		start_wait(8'h20, 100, 1'b1);
		samp_cyc = 0;
		repeat (100) @(negedge core_clk_i);
		check({31'h0000_0000, samp_cyc != 0}, 32'h0000_0001);
		conclude();
	end
endmodule // adc_control_prescaler_test
